// ===== design/sst_sector_timing.sv
`timescale 1ns/100ps
`include "sst_consts.svh"
module sst_sector_timing
(
  // Clock and reset (clock is the mark decoder clock)
  input wire logic core_clk,
  input wire logic sys_rst,
  // Dedicated servo inputs
  input wire logic servo_bit,
  input wire logic dedicated_sector_begin_n,
  input wire logic dedicated_sector_begin_p,
  // Servo controller enable
  input wire logic sector_begin_gate_en,
  // Outputs to read/write and DMA/ECC logic
  output logic sector_mark_found,
  output logic sector_begin_strobe_n,
  output logic data_field_open,
  output logic data_field_close
);
  import sst_pkg::*;

  sst_mark_if mk ();
  sst_state_t state;
  sst_state_t next_state;
  logic servo_field;
  logic gate_closed;
  logic next_strobe_n;
  logic strobe_q;

  // Mark decoder
  assign mk.servo_bit = servo_bit;
  sst_mark_decoder u_dec (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .mk(mk)
  );
  assign sector_mark_found = mk.found;

  // Servo field from the differential dedicated start pair
  assign servo_field = dedicated_sector_begin_p & ~dedicated_sector_begin_n;

  // Servo controller has withdrawn its enable
  assign gate_closed = ~sector_begin_gate_en;

  // Next state; every sector yields a field while the gate enable is high, no selection input exists
  always_comb
  begin
    next_state = state;
    unique case (state)
      SST_IDLE:
      begin
        if (sector_begin_gate_en)
        begin
          next_state = servo_field ? SST_SERVO : SST_DATA;
        end
      end
      SST_SERVO:
      begin
        if (gate_closed)
        begin
          next_state = SST_IDLE;
        end
        else if (!servo_field)
        begin
          next_state = SST_DATA;
        end
      end
      SST_DATA:
      begin
        if (gate_closed)
        begin
          next_state = SST_IDLE;
        end
        else if (servo_field)
        begin
          next_state = SST_SERVO;
        end
      end
      default:
      begin
        next_state = SST_IDLE;
      end
    endcase
  end

  // Strobe low only inside the data field
  assign next_strobe_n = (next_state == SST_DATA) ? 1'b0 : `SST_STROBE_IDLE;

  // Edge markers for the handshake user
  assign data_field_open = strobe_q & ~sector_begin_strobe_n;
  assign data_field_close = ~strobe_q & sector_begin_strobe_n;

  // State and strobe registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state <= SST_IDLE;
      sector_begin_strobe_n <= `SST_STROBE_IDLE;
      strobe_q <= `SST_STROBE_IDLE;
    end
    else
    begin
      state <= next_state;
      sector_begin_strobe_n <= next_strobe_n;
      strobe_q <= sector_begin_strobe_n;
    end
  end

  // Strobe stays high through the servo field
  servo_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    servo_field |=> sector_begin_strobe_n)
    else $error("strobe low in servo field");

  // Withdrawn enable forces the strobe high
  gate_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sector_begin_gate_en |=> sector_begin_strobe_n)
    else $error("strobe low while disabled");

  // Enabled data field opens on the next edge
  gate_open_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sector_begin_gate_en && !servo_field) |=> !sector_begin_strobe_n)
    else $error("data field not opened");

  // Each servo field is followed by a data field
  every_sector_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sector_begin_gate_en && servo_field) ##1 (sector_begin_gate_en && !servo_field)
      |=> !sector_begin_strobe_n)
    else $error("sector skipped");

  // Open marker only on a falling strobe
  open_edge_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    data_field_open |-> $fell(sector_begin_strobe_n))
    else $error("open marker wrong");

  // Close marker only on a rising strobe
  close_edge_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    data_field_close |-> $rose(sector_begin_strobe_n))
    else $error("close marker wrong");

  // Strobe falls only under enable
  strobe_reg_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(sector_begin_strobe_n) |-> $past(sector_begin_gate_en))
    else $error("strobe fell without enable");

  // Found needs the last pattern bit
  found_out_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sector_mark_found |-> $past(mk.servo_bit))
    else $error("found without final pattern bit");

  // Reset leaves every output idle
  reset_idle_a: assert property (@(posedge core_clk)
    sys_rst |=> (sector_begin_strobe_n && !sector_mark_found
      && !data_field_open && !data_field_close))
    else $error("outputs not idle after reset");

  // State register holds one legal code
  state_legal_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot(state))
    else $error("state code illegal");

  // Strobe is low exactly in the data state
  strobe_state_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sector_begin_strobe_n == (state != SST_DATA))
    else $error("strobe and state disagree");

  // Strobe low only after an enabled data field request
  strobe_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sector_begin_strobe_n |-> ($past(sector_begin_gate_en) && !$past(servo_field)))
    else $error("strobe low without request");

  // Open and close markers never coincide
  edge_excl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(data_field_open && data_field_close))
    else $error("open and close together");

  // Markers last a single cycle
  open_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    data_field_open |=> !data_field_open)
    else $error("open marker too long");
  close_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    data_field_close |=> !data_field_close)
    else $error("close marker too long");

  // End of servo field opens the data field
  field_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($fell(servo_field) && sector_begin_gate_en && $past(sector_begin_gate_en)) |=> data_field_open)
    else $error("data field start missed");

  // Start of servo field closes the data field
  field_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(servo_field) && sector_begin_gate_en && $past(sector_begin_gate_en) && !$past(sys_rst))
      |=> data_field_close)
    else $error("data field end missed");

  // A mark flag lasts a single cycle
  found_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sector_mark_found |=> !sector_mark_found)
    else $error("mark flag too long");

  // Main scenarios reached
  open_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) data_field_open);
  close_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) data_field_close);
  mark_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) sector_mark_found);
  // Enable withdrawn mid field, and back to back marks
  gate_drop_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    !sector_begin_strobe_n ##1 gate_closed ##1 sector_begin_strobe_n);
  mark_pair_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    sector_mark_found ##8 sector_mark_found);
endmodule : sst_sector_timing

// ===== design/sst_consts.svh
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH
// Sector mark pattern seen on the servo bit stream (8 bits)
`define SST_MARK_WIDTH 8
`define SST_MARK_PATTERN 8'ha5
// Reset values
`define SST_STROBE_IDLE 1'b1
`define SST_FOUND_IDLE 1'b0
`endif

// ===== design/sst_pkg.sv
package sst_pkg;
  // Strobe generator states
  typedef enum logic [2:0] {
    SST_IDLE = 3'b001,
    SST_SERVO = 3'b010,
    SST_DATA = 3'b100
  } sst_state_t;
endpackage : sst_pkg

// ===== design/sst_mark_if.sv
`timescale 1ns/100ps
interface sst_mark_if;
  logic servo_bit;
  logic found;
  modport decoder (input servo_bit, output found);
  modport user (output servo_bit, input found);
endinterface : sst_mark_if

// ===== design/sst_mark_decoder.sv
`timescale 1ns/100ps
`include "sst_consts.svh"
module sst_mark_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Servo stream and result
  sst_mark_if.decoder mk
);
  logic [`SST_MARK_WIDTH-1:0] shift;
  logic [`SST_MARK_WIDTH-1:0] next_shift;
  logic hit;
  logic found;

  // Pattern compare on the incoming window
  assign next_shift = {shift[`SST_MARK_WIDTH-2:0], mk.servo_bit};
  assign hit = (next_shift == `SST_MARK_PATTERN);
  assign mk.found = found;

  // Shift register and registered found flag
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      shift <= '0;
      found <= `SST_FOUND_IDLE;
    end
    else
    begin
      shift <= next_shift;
      found <= hit;
    end
  end

  mark_found_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (next_shift == `SST_MARK_PATTERN) |=> found)
    else $error("mark not flagged");
  found_reg_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    found |-> $past(hit))
    else $error("found without hit");
endmodule : sst_mark_decoder

// ===== test/sst_ctl_model.sv
`timescale 1ns/100ps
module sst_ctl_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // From sector timing
  input wire logic strobe_n,
  input wire logic found,
  // Position tracking
  output logic [7:0] sector_count,
  output logic xfer_start
);
  logic prev;
  // Transfer begins as the data field opens
  assign xfer_start = prev & ~strobe_n;
  // Count sectors, resync on each mark
  always_ff @(posedge core_clk)
  begin
    prev <= sys_rst | strobe_n;
    if (sys_rst | found)
      sector_count <= 8'h00;
    else if (~prev & strobe_n)
      sector_count <= sector_count + 8'h01;
  end
endmodule : sst_ctl_model

// ===== test/test_sector_start_timing.sv
`timescale 1ns/100ps
module test_sector_start_timing;
  logic core_clk = 0, sys_rst = 1, sb = 0, bn = 1, bp = 0, en = 0;
  logic found, strb_n, opn, cls, m_xfer, m_strb = 1;
  logic [7:0] m_win = 8'h00, m_cnt;
  logic [3:0] q[$];
  logic [3:0] e;
  logic [31:0] rs = 32'h00015446;
  logic [23:0] pat = 24'ha5a500;
  int failures = 0, num_checks = 0;
  always #5 core_clk = ~core_clk;
  sst_sector_timing i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .servo_bit(sb),
    .dedicated_sector_begin_n(bn), .dedicated_sector_begin_p(bp), .sector_begin_gate_en(en),
    .sector_mark_found(found), .sector_begin_strobe_n(strb_n), .data_field_open(opn), .data_field_close(cls));
  sst_ctl_model i_ctl (.core_clk(core_clk), .sys_rst(sys_rst), .strobe_n(strb_n), .found(found),
    .sector_count(m_cnt), .xfer_start(m_xfer));
  // Drive one cycle and note the expected outputs
  task automatic drv(input logic r, b, g, p, n);
    logic ns;
    @(posedge core_clk);
    #1;
    {sys_rst, sb, en, bp, bn} = {r, b, g, p, n};
    ns = r | ~g | (p & ~n);
    m_win = r ? 8'h00 : {m_win[6:0], b};
    q.push_back({m_win == 8'ha5, ns, ~r & m_strb & ~ns, ~r & ~m_strb & ns});
    m_strb = ns;
  endtask : drv
  task automatic chk(input string nm, input logic x, y);
    num_checks++;
    if (y !== x)
    begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", nm, x, y);
    end
  endtask : chk
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task stop_test;
    $display("checks %0d mismatches %0d sectors %0d", num_checks, failures, m_cnt);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // Compare outputs against the oldest note
  always @(posedge core_clk)
  begin
    #2;
    if (q.size() > 1)
    begin
      e = q.pop_front();
      chk("found", e[3], found);
      chk("strobe", e[2], strb_n);
      chk("open", e[1], opn);
      chk("close", e[0], cls);
      chk("xfer_start", e[1], m_xfer);
    end
  end
  // Gate sweep, back to back marks, random traffic
  initial
  begin
    repeat (4) drv(1, 0, 0, 0, 1);
    for (int i = 0; i < 32; i++) drv(0, 0, i[3], i[1], i[0]);
    $display("test gate done");
    for (int k = 0; k < 24; k++) drv(0, pat[23 - k], 1, k[2], 0);
    $display("test marks done");
    repeat (2000)
    begin
      rs = xs(rs);
      drv(rs[15:10] == 0, rs[0] & (rs[15:10] != 0), rs[8] | rs[9], rs[3], rs[4]);
    end
    $display("test random done");
    repeat (2) drv(0, 0, 0, 0, 1);
    stop_test();
  end
  // Watchdog
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end
endmodule : test_sector_start_timing
